// *** pkg/dsr_pkg.sv ***
// Purpose: constants and carrier types for the diagnostic status registers
// Assumes: 16-bit registers, word index addressing on a plain port
// Notes:   offsets are register indices
`default_nettype none
package dsr_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_PER_TICK   = 1;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000 * MS_PER_TICK;
  localparam int unsigned SEC_PER_MS    = 1000;

  localparam logic [4:0] OFS_FUSE      = 5'h00;
  localparam logic [4:0] OFS_DROP      = 5'h05;
  localparam logic [4:0] OFS_DIAG      = 5'h08;
  localparam logic [4:0] OFS_ETIME_YM  = 5'h0a;
  localparam logic [4:0] OFS_ETIME_DH  = 5'h0b;
  localparam logic [4:0] OFS_ETIME_MS  = 5'h0c;
  localparam logic [4:0] OFS_EINFO     = 5'h0e;
  localparam logic [4:0] OFS_RUNSTATE  = 5'h0f;
  localparam logic [4:0] OFS_CYC       = 5'h11;
  localparam logic [4:0] OFS_CYCMAX    = 5'h13;
  localparam logic [4:0] OFS_CAL_YM    = 5'h19;
  localparam logic [4:0] OFS_CAL_DH    = 5'h1a;
  localparam logic [4:0] OFS_CAL_MS    = 5'h1b;
  localparam logic [4:0] OFS_IRQ_STAT  = 5'h1c;
  localparam logic [4:0] OFS_IRQ_MASK  = 5'h1d;

  localparam logic [15:0] RST_CAL_YM   = 16'h0001;
  localparam logic [15:0] RST_CAL_DH   = 16'h0100;
  localparam logic [15:0] RST_ZERO     = 16'h0000;

  localparam logic [3:0] STATE_RUN     = 4'h0;
  localparam logic [3:0] STATE_STOP    = 4'h2;
  localparam logic [3:0] CAUSE_SWITCH  = 4'h0;
  localparam logic [3:0] CAUSE_ERROR   = 4'h4;
  localparam logic [15:0] CYC_SAT      = 16'hffff;

  localparam int unsigned IRQ_FUSE     = 0;
  localparam int unsigned IRQ_DROP     = 1;
  localparam int unsigned IRQ_DIAG     = 2;
  localparam int unsigned IRQ_CYCMAX   = 3;
  localparam int unsigned IRQ_W        = 4;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dsr_bus_req_type;

  typedef struct packed {
    logic [7:0] yy;
    logic [7:0] mo;
    logic [7:0] dd;
    logic [7:0] hh;
    logic [7:0] mi;
    logic [7:0] ss;
  } dsr_cal_type;
endpackage
`default_nettype wire

// *** rtl/dsr_regs.sv ***
// Purpose: diagnostic status register bank with running calendar
// Assumes: one clock, i_ref_clk at 125 MHz; event inputs from logic on it
// Notes:   voltage-drop and run-switch inputs are pins, synchronised here
`default_nettype none
module dsr_regs
  import dsr_pkg::*;
#(
  parameter int unsigned N_MOD     = 16,
  parameter int unsigned MS_COUNT  = MS_CYCLES
)(
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  input  wire logic [N_MOD-1:0]  i_fuse_blown,
  input  wire logic              i_supply_low,
  input  wire logic              i_dc_supply,
  input  wire logic              i_diag_valid,
  input  wire logic [15:0]       i_diag_code,
  input  wire logic [15:0]       i_diag_info,
  input  wire logic              i_run_switch,
  input  wire logic              i_main_pass,
  input  wire logic [4:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [15:0]            o_rdata,
  output logic                   o_irq
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second
  logic [1:0] sync_low;
  logic [1:0] sync_run;
  logic       low_q;
  logic       low_edge;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync_low <= 2'h0;
      sync_run <= 2'h0;
      low_q    <= 1'h0;
    end
    else
    begin
      sync_low <= {sync_low[0], i_supply_low};
      sync_run <= {sync_run[0], i_run_switch};
      low_q    <= sync_low[1];
    end
  end
  // the comparator sits outside; i_dc_supply picks its 65 vs 85 percent trip
  assign low_edge = sync_low[1] & ~low_q;

  dsr_bus_req_type req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  //////////////////////////////////////////////////////////////////////////
  // lowest blown-fuse module, priority encoder
  logic [15:0] next_fuse;
  always_comb
  begin
    next_fuse = RST_ZERO;
    for (int i = N_MOD - 1; i >= 0; i--)
      if (i_fuse_blown[i])
        next_fuse = 16'(i);
  end
  wire fuse_any = |i_fuse_blown;

  //////////////////////////////////////////////////////////////////////////
  // calendar: ms tick, then BCD seconds..years
  logic [31:0]  ms_cnt;
  logic [9:0]   ms_in_sec;
  dsr_cal_type  cal;
  wire ms_tick  = (ms_cnt == 32'(MS_COUNT - 1));
  wire sec_tick = ms_tick && (ms_in_sec == 10'(SEC_PER_MS - 1));

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  wire ss_wrap = sec_tick && cal.ss == 8'h59;
  wire mi_wrap = ss_wrap && cal.mi == 8'h59;
  wire hh_wrap = mi_wrap && cal.hh == 8'h23;
  wire dd_wrap = hh_wrap && cal.dd == 8'h30;
  wire mo_wrap = dd_wrap && cal.mo == 8'h12;
  wire sw_ym   = req.wr && req.addr == OFS_CAL_YM;
  wire sw_dh   = req.wr && req.addr == OFS_CAL_DH;
  wire sw_ms   = req.wr && req.addr == OFS_CAL_MS;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ms_cnt    <= 32'h0;
      ms_in_sec <= 10'h0;
      cal       <= {RST_CAL_YM, RST_CAL_DH, RST_ZERO};
    end
    else
    begin
      ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
      if (ms_tick)
        ms_in_sec <= sec_tick ? 10'h0 : ms_in_sec + 10'h1;
      // simple 30-day months; software write wins over rollover
      if (sec_tick)
        cal.ss <= ss_wrap ? 8'h00 : bcd_inc(cal.ss);
      if (ss_wrap)
        cal.mi <= mi_wrap ? 8'h00 : bcd_inc(cal.mi);
      if (mi_wrap)
        cal.hh <= hh_wrap ? 8'h00 : bcd_inc(cal.hh);
      if (hh_wrap)
        cal.dd <= dd_wrap ? 8'h01 : bcd_inc(cal.dd);
      if (dd_wrap)
        cal.mo <= mo_wrap ? 8'h01 : bcd_inc(cal.mo);
      if (mo_wrap)
        cal.yy <= (cal.yy == 8'h99) ? 8'h00 : bcd_inc(cal.yy);
      if (sw_ym)
        {cal.yy, cal.mo} <= req.wdata;
      if (sw_dh)
        {cal.dd, cal.hh} <= req.wdata;
      if (sw_ms)
        {cal.mi, cal.ss} <= req.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status registers
  logic [15:0] fuse_fault_module;
  logic [15:0] supply_drop_count;
  logic [15:0] diag_error_number;
  logic [15:0] err_time_year_month;
  logic [15:0] err_time_day_hour;
  logic [15:0] err_time_min_sec;
  logic [15:0] error_detail_info;
  logic [15:0] cpu_run_state;
  logic [15:0] cycle_time_ms;
  logic [15:0] cycle_time_max_ms;
  logic [15:0] cyc_run;
  logic        err_stop;
  logic        first_pass;

  wire running   = cpu_run_state[3:0] == STATE_RUN;
  wire drop_ev   = low_edge && running;
  wire cyc_sat   = cyc_run == CYC_SAT;
  wire cyc_newmax = i_main_pass && !first_pass && cyc_run > cycle_time_max_ms;
  // earliest cause holds: an error stop is not replaced by a later switch stop
  wire [3:0] next_cause = err_stop ? CAUSE_ERROR : CAUSE_SWITCH;
  wire [3:0] next_state = (err_stop || !sync_run[1]) ? STATE_STOP : STATE_RUN;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fuse_fault_module   <= RST_ZERO;
      supply_drop_count   <= RST_ZERO;
      diag_error_number   <= RST_ZERO;
      err_time_year_month <= RST_ZERO;
      err_time_day_hour   <= RST_ZERO;
      err_time_min_sec    <= RST_ZERO;
      error_detail_info   <= RST_ZERO;
      cpu_run_state       <= RST_ZERO;
      cycle_time_ms       <= RST_ZERO;
      cycle_time_max_ms   <= RST_ZERO;
      cyc_run             <= RST_ZERO;
      err_stop            <= 1'h0;
      first_pass          <= 1'h1;
    end
    else
    begin
      if (fuse_any)
        fuse_fault_module <= next_fuse;
      if (drop_ev)
        supply_drop_count <= supply_drop_count + 16'h1;
      if (i_diag_valid)
      begin
        diag_error_number   <= i_diag_code;
        err_time_year_month <= {cal.yy, cal.mo};
        err_time_day_hour   <= {cal.dd, cal.hh};
        err_time_min_sec    <= {cal.mi, cal.ss};
        error_detail_info   <= i_diag_info;
        err_stop            <= 1'h1;
      end
      if (i_main_pass)
      begin
        // stop cause keeps the one seen first until a run resumes
        if (cpu_run_state[3:0] == STATE_RUN || next_state == STATE_RUN)
          cpu_run_state <= {8'h00, next_cause, next_state};
        if (!first_pass)
          cycle_time_ms <= cyc_run;
        if (cyc_newmax)
          cycle_time_max_ms <= cyc_run;
        cyc_run    <= RST_ZERO;
        first_pass <= 1'h0;
      end
      else if (ms_tick && !cyc_sat)
        cyc_run <= cyc_run + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status (write one to clear, set wins) and mask
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  wire  [IRQ_W-1:0] irq_ev = {cyc_newmax, i_diag_valid, drop_ev, fuse_any};
  wire  [IRQ_W-1:0] irq_clr = (req.wr && req.addr == OFS_IRQ_STAT) ?
                              req.wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire              mask_wr = req.wr && req.addr == OFS_IRQ_MASK;
  // set wins: an event in the clear cycle stays visible
  wire  [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
  // output follows the new mask at once, so unmasking a pending bit is not late
  wire  [IRQ_W-1:0] next_irq_mask = mask_wr ? req.wdata[IRQ_W-1:0] : irq_mask;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      irq_stat <= {IRQ_W{1'b0}};
      irq_mask <= {IRQ_W{1'b0}};
      o_irq    <= 1'h0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      o_irq    <= |(next_irq_stat & next_irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero otherwise and unmapped
  logic [15:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      OFS_FUSE:     rd_mux = fuse_fault_module;
      OFS_DROP:     rd_mux = supply_drop_count;
      OFS_DIAG:     rd_mux = diag_error_number;
      OFS_ETIME_YM: rd_mux = err_time_year_month;
      OFS_ETIME_DH: rd_mux = err_time_day_hour;
      OFS_ETIME_MS: rd_mux = err_time_min_sec;
      OFS_EINFO:    rd_mux = error_detail_info;
      OFS_RUNSTATE: rd_mux = cpu_run_state;
      OFS_CYC:      rd_mux = cycle_time_ms;
      OFS_CYCMAX:   rd_mux = cycle_time_max_ms;
      OFS_CAL_YM:   rd_mux = {cal.yy, cal.mo};
      OFS_CAL_DH:   rd_mux = {cal.dd, cal.hh};
      OFS_CAL_MS:   rd_mux = {cal.mi, cal.ss};
      OFS_IRQ_STAT: rd_mux = 16'(irq_stat);
      OFS_IRQ_MASK: rd_mux = 16'(irq_mask);
      default:      rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= RST_ZERO;
    else
      o_rdata <= req.rd ? rd_mux : RST_ZERO;
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  fuse_lowest_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    fuse_any |=> fuse_fault_module == $past(next_fuse))
    else $error("fuse register not lowest module");
  drop_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    drop_ev |=> supply_drop_count == $past(supply_drop_count) + 16'h1)
    else $error("supply drop not counted");
  drop_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !drop_ev |=> $stable(supply_drop_count))
    else $error("supply drop count moved without event");
  diag_store_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_diag_valid |=> diag_error_number == $past(i_diag_code)
      && error_detail_info == $past(i_diag_info))
    else $error("diag error not stored");
  stamp_ym_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_diag_valid |=> err_time_year_month == $past({cal.yy, cal.mo}))
    else $error("year month stamp wrong");
  stamp_rest_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $changed(diag_error_number) |-> err_time_day_hour == $past({cal.dd, cal.hh})
      && err_time_min_sec == $past({cal.mi, cal.ss}))
    else $error("timestamps not loaded with error");
  err_cause_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    err_stop && i_main_pass && running |=> cpu_run_state[7:0] == {CAUSE_ERROR, STATE_STOP})
    else $error("error stop not reported");
  cyc_max_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_main_pass && !first_pass |=> cycle_time_max_ms >= cycle_time_ms)
    else $error("max cycle below current cycle");
  cyc_sat_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    cyc_sat && !i_main_pass |=> cyc_sat)
    else $error("cycle counter wrapped");

  //////////////////////////////////////////////////////////////////////////
  // hold checks: nothing moves without its event
  fuse_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !fuse_any |=> $stable(fuse_fault_module))
    else $error("fuse register moved with no fuse blown");
  drop_stopped_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    low_edge && !running |=> $stable(supply_drop_count))
    else $error("supply drop counted while stopped");
  diag_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_diag_valid |=> $stable(diag_error_number) && $stable(error_detail_info))
    else $error("diag error moved with no fault");
  state_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_main_pass |=> $stable(cpu_run_state))
    else $error("run state moved outside a main pass");
  cyc_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_main_pass |=> $stable(cycle_time_ms))
    else $error("cycle time moved outside a main pass");

  //////////////////////////////////////////////////////////////////////////
  // capture checks
  stamp_dh_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_diag_valid |=> err_time_day_hour == $past({cal.dd, cal.hh}))
    else $error("day hour stamp wrong");
  stamp_ms_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_diag_valid |=> err_time_min_sec == $past({cal.mi, cal.ss}))
    else $error("minute second stamp wrong");
  cyc_store_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_main_pass && !first_pass |=> cycle_time_ms == $past(cyc_run))
    else $error("cycle time not stored");
  max_mono_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !first_pass |=> cycle_time_max_ms >= $past(cycle_time_max_ms))
    else $error("max cycle time fell");
  max_track_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_main_pass && !first_pass |=> cycle_time_max_ms >= $past(cyc_run))
    else $error("max cycle below measured cycle");

  //////////////////////////////////////////////////////////////////////////
  // run state checks
  switch_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_main_pass && running && !err_stop && !sync_run[1]
      |=> cpu_run_state[7:0] == {CAUSE_SWITCH, STATE_STOP})
    else $error("switch stop not reported");
  run_resume_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_main_pass && !err_stop && sync_run[1]
      |=> cpu_run_state[7:0] == {CAUSE_SWITCH, STATE_RUN})
    else $error("run not resumed");
  cause_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !running && next_state != STATE_RUN |=> $stable(cpu_run_state))
    else $error("earliest stop cause replaced");

  //////////////////////////////////////////////////////////////////////////
  // calendar, read port and interrupt checks
  cal_ym_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    sw_ym |=> {cal.yy, cal.mo} == $past(req.wdata))
    else $error("year month write lost");
  cal_dh_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    sw_dh |=> {cal.dd, cal.hh} == $past(req.wdata))
    else $error("day hour write lost");
  rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !req.rd |=> o_rdata == RST_ZERO)
    else $error("read data outside read cycle");
  irq_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_irq == |(irq_stat & irq_mask))
    else $error("interrupt output not status and mask");
  irq_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    irq_ev != {IRQ_W{1'b0}} |=> (irq_stat & $past(irq_ev)) == $past(irq_ev))
    else $error("interrupt event lost to clear");

endmodule
`default_nettype wire

// *** bench/dsr_regs_tb.sv ***
// Purpose: self-checking bench for the diagnostic status registers
// Assumes: MS_COUNT set to 1 so a saturated cycle time fits in the run
// Notes:   synchronised pins need about 3 edges to act, waits allow 6
`default_nettype none
module dsr_regs_tb
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned MSC   = 1;
  localparam int unsigned LIMIT = 80000;

  logic        clk = 1'b0;
  logic        reset_n;
  logic [15:0] fuse;
  logic        supply;
  logic        dc;
  logic        dv;
  logic [15:0] code;
  logic [15:0] info;
  logic        sw;
  logic        pass;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [15:0] rdata;
  logic        irq;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #4 clk = ~clk;

  dsr_regs #(.N_MOD(16), .MS_COUNT(MSC)) uut (
    .i_ref_clk(clk), .i_reset_n(reset_n), .i_fuse_blown(fuse), .i_supply_low(supply),
    .i_dc_supply(dc), .i_diag_valid(dv), .i_diag_code(code), .i_diag_info(info),
    .i_run_switch(sw), .i_main_pass(pass), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // a hung wait ends the run here rather than stalling
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      $display("unexpected at %0t: run too long", $time);
      final_report();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // cycle lengths may land one ms either side, depending on tick phase
  task automatic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    check({15'h0000, (v >= lo) && (v <= hi)}, 16'h0001);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  task automatic pulse_pass;
    @(posedge clk);
    pass <= 1'b1;
    @(posedge clk);
    pass <= 1'b0;
  endtask

  task automatic irqchk(input logic exp);
    idle(2);
    #1 check({15'h0000, irq}, {15'h0000, exp});
  endtask

  task automatic set_low(input logic v);
    @(posedge clk);
    supply <= v;
    idle(6);
  endtask

  task automatic set_run(input logic v);
    @(posedge clk);
    sw <= v;
    idle(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(OFS_FUSE, RST_ZERO);
    rdchk(OFS_DROP, RST_ZERO);
    rdchk(OFS_CAL_YM, RST_CAL_YM);
    rdchk(OFS_CAL_DH, RST_CAL_DH);
    rdchk(5'h1e, RST_ZERO);
    wr(OFS_DIAG, 16'h5555);
    rdchk(OFS_DIAG, RST_ZERO);
    irqchk(1'b0);
  endtask

  task automatic t_fuse;
    @(posedge clk);
    fuse <= 16'h8028;
    idle(3);
    rdchk(OFS_FUSE, 16'h0003);
    @(posedge clk);
    fuse <= 16'h8000;
    idle(3);
    rdchk(OFS_FUSE, 16'h000f);
    @(posedge clk);
    fuse <= 16'h0000;
  endtask

  task automatic t_cycle;
    logic [15:0] v;
    pulse_pass();
    idle(40);
    pulse_pass();
    idle(8);
    pulse_pass();
    idle(2);
    rd(OFS_CYC, v);
    in_range(v, 16'd9, 16'd11);
    rd(OFS_CYCMAX, v);
    in_range(v, 16'd41, 16'd43);
    rdchk(OFS_RUNSTATE, {8'h00, CAUSE_SWITCH, STATE_RUN});
  endtask

  task automatic t_drop;
    repeat (2)
    begin
      set_low(1'b1);
      set_low(1'b0);
    end
    rdchk(OFS_DROP, 16'h0002);
    set_run(1'b0);
    pulse_pass();
    idle(2);
    rdchk(OFS_RUNSTATE, {8'h00, CAUSE_SWITCH, STATE_STOP});
    set_low(1'b1);
    set_low(1'b0);
    rdchk(OFS_DROP, 16'h0002);
    set_run(1'b1);
    pulse_pass();
    idle(2);
    rdchk(OFS_RUNSTATE, {8'h00, CAUSE_SWITCH, STATE_RUN});
  endtask

  task automatic t_diag;
    logic [15:0] v;
    wr(OFS_CAL_YM, 16'h9510);
    wr(OFS_CAL_DH, 16'h2510);
    wr(OFS_CAL_MS, 16'h3548);
    rdchk(OFS_CAL_YM, 16'h9510);
    rdchk(OFS_CAL_DH, 16'h2510);
    @(posedge clk);
    dv <= 1'b1;
    code <= 16'h1234;
    info <= 16'h0004;
    @(posedge clk);
    dv <= 1'b0;
    code <= 16'h0000;
    info <= 16'h0000;
    rdchk(OFS_DIAG, 16'h1234);
    rdchk(OFS_ETIME_YM, 16'h9510);
    rdchk(OFS_ETIME_DH, 16'h2510);
    rd(OFS_ETIME_MS, v);
    in_range(v, 16'h3548, 16'h3549);
    rdchk(OFS_EINFO, 16'h0004);
    irqchk(1'b0);
    wr(OFS_IRQ_MASK, 16'h0004);
    irqchk(1'b1);
    wr(OFS_IRQ_STAT, 16'h0004);
    irqchk(1'b0);
    rdchk(OFS_IRQ_MASK, 16'h0004);
    rdchk(OFS_IRQ_STAT, 16'h000b);
    wr(OFS_IRQ_STAT, 16'h000f);
    rdchk(OFS_IRQ_STAT, 16'h0000);
    pulse_pass();
    idle(2);
    rdchk(OFS_RUNSTATE, {8'h00, CAUSE_ERROR, STATE_STOP});
  endtask

  // long pass: 65600 ms at one cycle per ms must clamp
  task automatic t_sat;
    pulse_pass();
    idle(65600);
    pulse_pass();
    idle(2);
    rdchk(OFS_CYC, CYC_SAT);
    rdchk(OFS_CYCMAX, CYC_SAT);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    fuse = 16'h0000;
    supply = 1'b0;
    dc = 1'b0;
    dv = 1'b0;
    code = 16'h0000;
    info = 16'h0000;
    sw = 1'b1;
    pass = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    idle(2);
    reset_n <= 1'b1;
    t_reset();
    t_fuse();
    t_cycle();
    t_drop();
    t_diag();
    t_sat();
    final_report();
  end
endmodule
`default_nettype wire
